// ==== acmpc_cfg.svh ====
// Constants for the comparator output control block.
// Assumes inclusion by acmpc_top.
`ifndef ACMPC_CFG_SVH
`define ACMPC_CFG_SVH
`define ACMPC_NEG_PIN0 3'h0
`define ACMPC_NEG_PIN2 3'h2
`define ACMPC_NEG_PIN3 3'h3
`define ACMPC_NEG_REF 3'h4
`define ACMPC_POS_PIN0 3'h0
`define ACMPC_POS_PIN3 3'h3
`define ACMPC_POS_PIN4 3'h4
`define ACMPC_REF_RESET 8'hFF
`define ACMPC_SYNC_STAGES 2
`define ACMPC_STARTUP_NS 1000
`define ACMPC_CLK_PERIOD_NS 10
`define ACMPC_STARTUP_CYCLES ((`ACMPC_STARTUP_NS + `ACMPC_CLK_PERIOD_NS - 1) / `ACMPC_CLK_PERIOD_NS)
`endif

// ==== acmpc_pkg.sv ====
// Types for the comparator output control block.
// Assumes nothing beyond the constants header.
package acmpc_pkg;
  typedef enum logic [1:0] {ACMPC_INT_OFF, ACMPC_INT_RISE, ACMPC_INT_FALL, ACMPC_INT_BOTH}
    acmpc_intmode_type;
  typedef enum logic [1:0] {ACMPC_HYS_NONE, ACMPC_HYS_SMALL, ACMPC_HYS_MEDIUM, ACMPC_HYS_LARGE}
    acmpc_hys_type;
endpackage : acmpc_pkg

// ==== acmpc_sync.sv ====
// Two-stage level synchroniser for the asynchronous comparator result.
// Assumes the input may change at any time relative to sys_clk.
`timescale 1ns/1ps
module acmpc_sync #(
  parameter int STAGES = 2
) (
  input wire logic sys_clk, // Clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic async_in, // Asynchronous level
  output logic sync_out // Synchronised level
);
  logic [STAGES-1:0] chain_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      chain_q <= '0;
    else
      chain_q <= {chain_q[STAGES-2:0], async_in};
  end

  assign sync_out = chain_q[STAGES-1];
endmodule : acmpc_sync

// ==== acmpc_top.sv ====
// Digital control around an analog comparator: input selects, start-up hold,
// inversion, pin and event outputs, edge interrupt flag.
// Assumes the analog core delivers an asynchronous compare result.
`timescale 1ns/1ps
`include "acmpc_cfg.svh"
module acmpc_top
  import acmpc_pkg::*;
#(
  parameter int STARTUP_CYCLES = `ACMPC_STARTUP_CYCLES
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic enable, // Comparator enable
  input wire logic pin_output_enable, // Drive result to pin
  input wire logic [1:0] hysteresis_select, // Hysteresis level
  input wire logic [1:0] power_profile, // Current vs speed
  input wire logic output_invert, // Invert output
  input wire logic output_initial_value, // Level during start-up
  input wire logic [2:0] positive_input_select, // Positive mux code
  input wire logic [2:0] negative_input_select, // Negative mux code
  input wire logic [7:0] reference_level_code, // Reference level code
  input wire logic [1:0] int_mode, // Edge sense mode
  input wire logic int_enable, // Interrupt enable
  input wire logic flag_clear, // Clear compare_flag, pulse
  input wire logic analog_raw_result, // Async compare from core
  output logic [1:0] analog_hys_level, // To core hysteresis
  output logic [1:0] analog_power_level, // To core bias
  output logic analog_core_enable, // To core enable
  output logic [2:0] analog_pos_pin, // One-hot positive pins 0,3,4
  output logic [2:0] analog_neg_pin, // One-hot negative pins 0,2,3
  output logic analog_neg_use_ref, // Negative from reference
  output logic [7:0] analog_ref_code, // Reference DAC code
  output logic select_reserved, // A reserved mux code is set
  output logic comparator_ready, // Start-up done
  output logic comparator_state, // Synchronised output
  output logic out_pin, // Pin output level
  output logic out_pin_oe, // Pin output enable
  output logic event_level, // Async level event
  output logic compare_flag, // Sticky edge flag
  output logic irq // Interrupt request
);

  ////////////////////////////////////////////////////////////////////////////
  // Input selection and analog controls

  function automatic logic [3:0] acmpc_neg_decode(input logic [2:0] code);
    case (code)
      `ACMPC_NEG_PIN0: acmpc_neg_decode = 4'h1;
      `ACMPC_NEG_PIN2: acmpc_neg_decode = 4'h2;
      `ACMPC_NEG_PIN3: acmpc_neg_decode = 4'h4;
      `ACMPC_NEG_REF: acmpc_neg_decode = 4'h8;
      default: acmpc_neg_decode = 4'h0;
    endcase
  endfunction : acmpc_neg_decode

  function automatic logic [2:0] acmpc_pos_decode(input logic [2:0] code);
    case (code)
      `ACMPC_POS_PIN0: acmpc_pos_decode = 3'h1;
      `ACMPC_POS_PIN3: acmpc_pos_decode = 3'h2;
      `ACMPC_POS_PIN4: acmpc_pos_decode = 3'h4;
      default: acmpc_pos_decode = 3'h0;
    endcase
  endfunction : acmpc_pos_decode

  logic [3:0] neg_sel;
  logic [2:0] pos_sel;
  assign neg_sel = acmpc_neg_decode(negative_input_select);
  assign pos_sel = acmpc_pos_decode(positive_input_select);

  // Mux controls come from flops so the analog switches never see glitches
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      analog_pos_pin <= 3'h0;
      analog_neg_pin <= 3'h0;
      analog_neg_use_ref <= 1'b0;
      analog_ref_code <= `ACMPC_REF_RESET;
      select_reserved <= 1'b0;
    end
    else
    begin
      analog_pos_pin <= pos_sel;
      analog_neg_pin <= neg_sel[2:0];
      analog_neg_use_ref <= neg_sel[3];
      analog_ref_code <= reference_level_code;
      select_reserved <= (pos_sel == 3'h0) || (neg_sel == 4'h0);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      analog_hys_level <= ACMPC_HYS_NONE;
      analog_power_level <= 2'h0;
      analog_core_enable <= 1'b0;
    end
    else
    begin
      analog_hys_level <= hysteresis_select;
      analog_power_level <= power_profile;
      analog_core_enable <= enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up hold

  localparam int CW = $clog2(STARTUP_CYCLES + 1);
  logic [CW-1:0] start_cnt_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !enable)
      start_cnt_q <= '0;
    else if (start_cnt_q != CW'(STARTUP_CYCLES))
      start_cnt_q <= start_cnt_q + CW'(1);
  end

  assign comparator_ready = enable && (start_cnt_q == CW'(STARTUP_CYCLES));

  ////////////////////////////////////////////////////////////////////////////
  // Output conditioning; asynchronous path by design

  logic cond_out;
  // Core result already means positive above negative
  assign cond_out = comparator_ready ? (analog_raw_result ^ output_invert)
                                     : output_initial_value;
  assign out_pin = cond_out;
  assign out_pin_oe = pin_output_enable;
  // Level event follows the output itself; there is no event input port
  assign event_level = cond_out;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and sticky flag

  logic sync_lvl;
  logic state_q;
  logic rise;
  logic fall;
  logic edge_hit;
  logic [1:0] settle_q;

  // Edges are ignored until the synchroniser has refilled after reset, so a
  // high idle level does not show up as a false rising edge
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      settle_q <= 2'h0;
    else if (settle_q != 2'h3)
      settle_q <= settle_q + 2'h1;
  end

  acmpc_sync #(.STAGES(`ACMPC_SYNC_STAGES)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(cond_out),
    .sync_out(sync_lvl)
  );

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_q <= 1'b0;
    else
      state_q <= sync_lvl;
  end

  assign comparator_state = state_q;
  assign rise = sync_lvl && !state_q && (settle_q == 2'h3);
  assign fall = !sync_lvl && state_q && (settle_q == 2'h3);

  always_comb
  begin
    case (acmpc_intmode_type'(int_mode))
      ACMPC_INT_RISE: edge_hit = rise;
      ACMPC_INT_FALL: edge_hit = fall;
      ACMPC_INT_BOTH: edge_hit = rise || fall;
      default: edge_hit = 1'b0;
    endcase
  end

  // A new edge wins over a clear arriving in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      compare_flag <= 1'b0;
    else if (edge_hit)
      compare_flag <= 1'b1;
    else if (flag_clear)
      compare_flag <= 1'b0;
  end

  assign irq = compare_flag && int_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_edge;
    edge_hit;
  endsequence

  property p_flag_set;
    @(posedge sys_clk) disable iff (sys_rst) s_edge |=> compare_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on edge");

  property p_flag_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      compare_flag && !flag_clear |=> compare_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

  property p_no_spurious;
    @(posedge sys_clk) disable iff (sys_rst)
      !compare_flag && !edge_hit |=> !compare_flag;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set without edge");

  property p_init_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      !comparator_ready |-> out_pin == output_initial_value;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("start-up level wrong");

  property p_invert;
    @(posedge sys_clk) disable iff (sys_rst)
      comparator_ready |-> out_pin == (analog_raw_result ^ output_invert);
  endproperty
  a_invert: assert property (p_invert) else $error("inversion wrong");

  property p_oe;
    @(posedge sys_clk) disable iff (sys_rst) out_pin_oe == pin_output_enable;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");

  property p_event;
    @(posedge sys_clk) disable iff (sys_rst) event_level == out_pin;
  endproperty
  a_event: assert property (p_event) else $error("event not output level");

  property p_neg_ref;
    @(posedge sys_clk) disable iff (sys_rst)
      negative_input_select == `ACMPC_NEG_REF |=> analog_neg_use_ref && analog_neg_pin == 3'h0;
  endproperty
  a_neg_ref: assert property (p_neg_ref) else $error("reference select wrong");

  property p_sync_delay;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(cond_out) ##1 cond_out[*2] |-> ##1 comparator_state;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync latency wrong");

endmodule : acmpc_top

// ==== acmpc_core_model.sv ====
// Behavioural analog core facing the comparator control block.
// Assumes pin levels come from the bench in units of the reference voltage over 256.
`timescale 1ns/1ps
module acmpc_core_model (
  input wire logic sys_clk, // Clock for the unsettled pattern
  input wire logic core_en, // Core enable
  input wire logic [2:0] pos_pin, // One-hot positive pins
  input wire logic [2:0] neg_pin, // One-hot negative pins
  input wire logic use_ref, // Negative taken from reference
  input wire logic [7:0] ref_code, // Reference level code
  input wire logic [23:0] pos_v, // Positive pin levels, 8 bits each
  input wire logic [23:0] neg_v, // Negative pin levels, 8 bits each
  output logic raw // Compare result
);
  logic idle_q = 1'b0;
  logic [8:0] vp;
  logic [8:0] vn;
  // A disabled core has no settled answer, so it toggles rather than hold a level
  always_ff @(posedge sys_clk)
  begin
    idle_q <= ~idle_q;
  end
  always_comb
  begin
    vp = 9'h000;
    vn = 9'h000;
    for (int i = 0; i < 3; i++)
    begin
      if (pos_pin[i]) vp = {1'b0, pos_v[8*i +: 8]};
      if (neg_pin[i]) vn = {1'b0, neg_v[8*i +: 8]};
    end
    if (use_ref) vn = {1'b0, ref_code};
    raw = core_en ? (vp > vn) : idle_q;
  end
endmodule : acmpc_core_model

// ==== tb.sv ====
// Self-checking bench for the comparator output control block.
// Assumes the core model file is compiled before this one.
`timescale 1ns/1ps
module tb
  import acmpc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst, enable, pin_output_enable, output_invert, output_initial_value;
  logic int_enable, flag_clear, raw, use_ref, sel_res, ready, state, out_pin, oe, ev, flag, irq;
  logic core_en;
  logic [1:0] hysteresis_select, power_profile, int_mode, hys, pwr;
  logic [2:0] positive_input_select, negative_input_select, pos_pin, neg_pin;
  logic [7:0] reference_level_code, ref_code;
  logic [23:0] pos_v, neg_v;
  int num_errors = 0;
  int comparisons = 0;
  int n;
  always #5 sys_clk = ~sys_clk;
  acmpc_top #(.STARTUP_CYCLES(4)) acmpc_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .enable(enable), .pin_output_enable(pin_output_enable), .hysteresis_select(hysteresis_select),
    .power_profile(power_profile), .output_invert(output_invert),
    .output_initial_value(output_initial_value), .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select), .reference_level_code(reference_level_code),
    .int_mode(int_mode), .int_enable(int_enable), .flag_clear(flag_clear),
    .analog_raw_result(raw), .analog_hys_level(hys), .analog_power_level(pwr),
    .analog_core_enable(core_en), .analog_pos_pin(pos_pin), .analog_neg_pin(neg_pin),
    .analog_neg_use_ref(use_ref), .analog_ref_code(ref_code), .select_reserved(sel_res),
    .comparator_ready(ready), .comparator_state(state), .out_pin(out_pin), .out_pin_oe(oe),
    .event_level(ev), .compare_flag(flag), .irq(irq));
  acmpc_core_model acmpc_core_model_inst (.sys_clk(sys_clk), .core_en(core_en),
    .pos_pin(pos_pin), .neg_pin(neg_pin), .use_ref(use_ref), .ref_code(ref_code),
    .pos_v(pos_v), .neg_v(neg_v), .raw(raw));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {enable, pin_output_enable, output_invert, output_initial_value, int_enable} = 5'h00;
    {flag_clear, hysteresis_select, power_profile, int_mode} = 7'h00;
    {positive_input_select, negative_input_select, reference_level_code} = 14'h0000;
    {pos_v, neg_v} = 48'h0;
    sys_rst = 1'b1;
    step(16);
    check(ref_code, 8'hFF);
    check(flag, 1'b0);
    sys_rst = 1'b0;
    begin : scenarios
    for (int c = 0; c < 8; c++)
    begin
      positive_input_select = c[2:0];
      negative_input_select = c[2:0];
      step(2);
      check(pos_pin, {c == 4, c == 3, c == 0});
      check(neg_pin, {c == 3, c == 2, c == 0});
      check(use_ref, c == 4);
      check(sel_res, !(c == 0 || c == 3 || c == 4));
    end
    for (int i = 0; i < 4; i++)
    begin
      hysteresis_select = i[1:0];
      power_profile = 2'h3 - i[1:0];
      step(2);
      check(hys, 8'(i));
      check(pwr, 8'(3 - i));
    end
    $display("end of select decode");
    // Keep the simulated part ordered: selects, pin, enable last
    positive_input_select = 3'h3;
    negative_input_select = 3'h4;
    reference_level_code = 8'h80;
    pos_v = 24'h004000;
    output_initial_value = 1'b1;
    pin_output_enable = 1'b1;
    step(2);
    enable = 1'b1;
    step(1);
    check(out_pin, 1'b1);
    check(ev, 1'b1);
    n = 0;
    while (!ready && n < 10)
    begin
      step(1);
      n++;
    end
    if (n == 10)
    begin
      num_errors++;
      disable scenarios;
    end
    // Two spare cycles before checking; the design has no separate reference start-up
    step(2);
    check(out_pin, 1'b0);
    check(core_en, 1'b1);
    check(ref_code, 8'h80);
    $display("end of start-up");
    for (int v = 0; v < 6; v++)
    begin
      pos_v[15:8] = 8'h7F + v[7:0] % 3;
      output_invert = v / 3;
      step(2);
      check(out_pin, (v % 3 == 2) ^ (v / 3));
      check(ev, out_pin);
    end
    negative_input_select = 3'h2;
    neg_v[15:8] = 8'h90;
    output_invert = 1'b0;
    step(2);
    check(out_pin, 1'b0);
    pin_output_enable = 1'b0;
    step(1);
    check(oe, 1'b0);
    $display("end of compare path");
    for (int m = 0; m < 4; m++)
    begin
      int_mode = m[1:0];
      int_enable = 1'b1;
      flag_clear = 1'b1;
      step(1);
      flag_clear = 1'b0;
      neg_v[15:8] = 8'h70;
      step(8);
      check(flag, m == ACMPC_INT_RISE || m == ACMPC_INT_BOTH);
      check(irq, m == ACMPC_INT_RISE || m == ACMPC_INT_BOTH);
      check(state, 1'b1);
      flag_clear = 1'b1;
      step(1);
      flag_clear = 1'b0;
      neg_v[15:8] = 8'h90;
      step(8);
      check(flag, m >= 2);
      check(state, 1'b0);
    end
    int_enable = 1'b0;
    step(1);
    check(irq, 1'b0);
    // Clear held high while an edge arrives: the edge wins for one cycle
    flag_clear = 1'b1;
    neg_v[15:8] = 8'h70;
    step(3);
    check(flag, 1'b1);
    step(1);
    check(flag, 1'b0);
    flag_clear = 1'b0;
    $display("end of edge flags");
    output_initial_value = 1'b0;
    pin_output_enable = 1'b1;
    enable = 1'b0;
    step(1);
    check(ready, 1'b0);
    check(out_pin, 1'b0);
    check(oe, 1'b1);
    $display("end of disable");
    end : scenarios
    complete_run();
  end
endmodule : tb
